// ==== fcdma_pkg.sv ====
// Shared map, field layouts and state codes of the four-channel memory mover
// How it works
// - Four channels run independent transfers.
// - Each burst moves one or two bytes.
// - Block size one byte up to 64KB.
// - Repeat runs each block once more.
// - Source and destination fixed or incrementing.
// - Address reload per burst, block or transaction.
// - Start by software, peripheral or event.
// - Every channel holds its own settings.
// - Per-channel interrupts on completion and error.
// - Linked channel starts when previous finishes.
// - Pairing holds off the odd channel of each pair.
// - Memory and peripheral transfers in any direction.
// - Moved bytes optionally feed the CRC generator.
package fcdma_pkg;
	localparam int NCH = 4;
	localparam int CHW = 2;
	localparam int AW  = 16;
	localparam int CH_LSB = 4;
	localparam int BLKW = 17;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_SRC   = 8'h04;
	localparam logic [7:0] OFS_DST   = 8'h08;
	localparam logic [7:0] OFS_CNT   = 8'h0c;
	localparam logic [7:0] OFS_MASK  = 8'h0f;
	localparam logic [7:0] OFS_GCTRL = 8'h40;
	localparam logic [7:0] OFS_STAT  = 8'h44;
	localparam logic [31:0] CTRL_WMASK = 32'hff01_fffd;
	// Global control bit positions
	localparam int GC_EN = 0;
	localparam int GC_RR = 1;
	localparam int GC_PAIR = 2;
	localparam int GCW = 4;
	// Status field positions
	localparam int SF_DONE  = 0;
	localparam int SF_ERR   = 4;
	localparam int SF_MATCH = 8;
	localparam int SF_BUSY  = 12;
	// Trigger sources and reload points
	localparam logic [1:0] TRG_SW  = 2'h0;
	localparam logic [1:0] TRG_PER = 2'h1;
	localparam logic [1:0] TRG_EVT = 2'h2;
	localparam logic [1:0] RLD_NONE  = 2'h0;
	localparam logic [1:0] RLD_BURST = 2'h1;
	localparam logic [1:0] RLD_BLOCK = 2'h2;
	localparam logic [1:0] RLD_TXN   = 2'h3;
	localparam logic [BLKW-1:0] BLK_MAX = 17'h10000;
	localparam logic [BLKW-1:0] BLK_ONE = 17'h00001;
	typedef struct packed {
		logic [7:0] pattern;
		logic [6:0] rsvd;
		logic       search;
		logic       link;
		logic       crc;
		logic       ie_err;
		logic       ie_done;
		logic [1:0] dst_rld;
		logic [1:0] src_rld;
		logic       dst_inc;
		logic       src_inc;
		logic [1:0] trig;
		logic       rpt;
		logic       burst2;
		logic       swreq;
		logic       en;
	} fcdma_ctrl_s;
	typedef struct packed {
		logic          req;
		logic          we;
		logic [AW-1:0] addr;
		logic [7:0]    wdata;
	} fcdma_mreq_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RD   = 3'b010,
		ST_WR   = 3'b100
	} fcdma_state_e;
endpackage

// ==== fcdma_addr.sv ====
// Next-address step with increment and reload
`timescale 1ns/100ps
module fcdma_addr import fcdma_pkg::*; (
	input  wire logic [AW-1:0] cur,
	input  wire logic [AW-1:0] start,
	input  wire logic          inc,
	input  wire logic [1:0]    rld,
	input  wire logic          burst_end,
	input  wire logic          block_end,
	input  wire logic          txn_end,
	output logic [AW-1:0]      nxt
);
	// Step, then restore the start address at the chosen boundary
	always_comb begin
		nxt = inc ? AW'(cur + 1'b1) : cur;
		case (rld)
			RLD_BURST: if (burst_end) nxt = start;
			RLD_BLOCK: if (block_end) nxt = start;
			RLD_TXN:   if (txn_end) nxt = start;
			default:   nxt = nxt;
		endcase
	end
endmodule

// ==== fcdma_arb.sv ====
// Channel arbiter: fixed or round-robin priority
`timescale 1ns/100ps
module fcdma_arb import fcdma_pkg::*; (
	input  wire logic           core_clk,
	input  wire logic           rst_n,
	input  wire logic [NCH-1:0] req,
	input  wire logic           rr,
	input  wire logic           take,
	output logic [CHW-1:0]      gnt_idx,
	output logic                gnt_vld
);
	logic [CHW-1:0] last_q;

	// First requester at or after the start index
	function automatic logic [CHW-1:0] pick(input logic [NCH-1:0] r, input logic [CHW-1:0] s);
		logic [CHW-1:0] k;
		pick = s;
		for (int i = NCH - 1; i >= 0; i--) begin
			k = CHW'(s + CHW'(i));
			if (r[k]) pick = k;
		end
	endfunction

	// Channel 0 highest when fixed, rotating when round robin
	assign gnt_idx = pick(req, rr ? CHW'(last_q + 1'b1) : '0);
	assign gnt_vld = |req;

	// Remember the last winner
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_q <= '0;
		end else if (take) begin
			last_q <= gnt_idx;
		end
	end
endmodule

// ==== fcdma_top.sv ====
// Four-channel memory mover: APB registers, burst engine, channel state
`timescale 1ns/100ps
module fcdma_top import fcdma_pkg::*; (
	input  wire logic           core_clk,
	input  wire logic           rst_n,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output logic [31:0]         prdata,
	output logic                pready,
	output logic                pslverr,
	output fcdma_mreq_s         mem_o,
	input  wire logic           mem_ack,
	input  wire logic           mem_err,
	input  wire logic [7:0]     mem_rdata,
	input  wire logic [NCH-1:0] periph_req,
	input  wire logic [NCH-1:0] evt_trig,
	output logic                crc_valid,
	output logic [7:0]          crc_data,
	output logic [NCH-1:0]      irq_done,
	output logic [NCH-1:0]      irq_err
);
	fcdma_ctrl_s    ctrl_q [NCH];
	logic [AW-1:0]  src_base_q [NCH];
	logic [AW-1:0]  dst_base_q [NCH];
	logic [AW-1:0]  src_cur_q [NCH];
	logic [AW-1:0]  dst_cur_q [NCH];
	logic [AW-1:0]  blk_q [NCH];
	logic [BLKW-1:0] rem_q [NCH];
	logic [NCH-1:0] rep_q;
	logic [NCH-1:0] pend_q;
	logic [NCH-1:0] done_q;
	logic [NCH-1:0] err_q;
	logic [NCH-1:0] match_q;
	logic [GCW-1:0] gctrl_q;
	fcdma_state_e   st_q;
	logic [CHW-1:0] act_q;
	logic [7:0]     data_q;
	logic           beat_q;
	fcdma_mreq_s    mem_q;
	logic [31:0]    prdata_q;
	logic           crc_valid_q;
	logic [7:0]     crc_data_q;
	fcdma_ctrl_s    ac;
	logic [NCH-1:0] elig;
	logic [NCH-1:0] trig_hit;
	logic [NCH-1:0] busy;
	logic [NCH-1:0] pend_set;
	logic [NCH-1:0] pend_clr;
	logic [CHW-1:0] gnt_idx;
	logic [CHW-1:0] a_ch;
	logic [CHW-1:0] nxt_ch;
	logic [7:0]     a_ofs;
	logic           gnt_vld;
	logic           start;
	logic           rd_ack;
	logic           wr_ack;
	logic           bus_err;
	logic           last_byte;
	logic           match_w;
	logic           block_end;
	logic           txn_end;
	logic           burst_end;
	logic           a_is_ch;
	logic           mapped;
	logic           apb_wr;
	logic [AW-1:0]  src_nxt;
	logic [AW-1:0]  dst_nxt;

	// Block length from the size field, zero meaning the largest block
	function automatic logic [BLKW-1:0] blk_len(input logic [AW-1:0] b);
		blk_len = (b == '0) ? BLK_MAX : {1'b0, b};
	endfunction

	// APB decode: channel window below the global registers
	assign a_ch    = paddr[CH_LSB +: CHW];
	assign a_ofs   = paddr & OFS_MASK;
	assign a_is_ch = paddr < OFS_GCTRL;
	assign mapped  = (a_is_ch && (a_ofs == OFS_CTRL || a_ofs == OFS_SRC || a_ofs == OFS_DST
		|| a_ofs == OFS_CNT)) || paddr == OFS_GCTRL || paddr == OFS_STAT;
	assign apb_wr  = psel && penable && pwrite && mapped;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_q;

	// Engine status terms
	assign ac        = ctrl_q[act_q];
	assign rd_ack    = st_q == ST_RD && mem_ack && !mem_err;
	assign wr_ack    = st_q == ST_WR && mem_ack && !mem_err;
	assign bus_err   = st_q != ST_IDLE && mem_ack && mem_err;
	assign last_byte = rem_q[act_q] == BLK_ONE;
	assign match_w   = ac.search && data_q == ac.pattern;
	assign block_end = wr_ack && last_byte;
	assign txn_end   = wr_ack && ((block_end && (!ac.rpt || rep_q[act_q])) || match_w);
	assign burst_end = wr_ack && (!ac.burst2 || beat_q || last_byte || match_w);
	assign start     = st_q == ST_IDLE && gnt_vld;
	assign nxt_ch    = CHW'(act_q + 1'b1);
	assign mem_o     = mem_q;
	assign crc_valid = crc_valid_q;
	assign crc_data  = crc_data_q;

	// Per-channel trigger select, eligibility and interrupt lines
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		assign trig_hit[g] = (ctrl_q[g].trig == TRG_PER && periph_req[g])
			|| (ctrl_q[g].trig == TRG_EVT && evt_trig[g]);
		assign elig[g] = gctrl_q[GC_EN] && ctrl_q[g].en && pend_q[g]
			&& !((g % 2 == 1) && gctrl_q[GC_PAIR + g / 2]);
		assign busy[g]     = st_q != ST_IDLE && act_q == CHW'(g);
		assign irq_done[g] = done_q[g] && ctrl_q[g].ie_done;
		assign irq_err[g]  = err_q[g] && ctrl_q[g].ie_err;
		assign pend_set[g] = trig_hit[g] || (apb_wr && a_is_ch && a_ch == CHW'(g)
			&& a_ofs == OFS_CTRL && pwdata[1]) || (txn_end && ac.link && nxt_ch == CHW'(g));
		assign pend_clr[g] = start && gnt_idx == CHW'(g);
	end

	fcdma_arb u_arb (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.req      (elig),
		.rr       (gctrl_q[GC_RR]),
		.take     (start),
		.gnt_idx  (gnt_idx),
		.gnt_vld  (gnt_vld)
	);

	fcdma_addr u_src (
		.cur       (src_cur_q[act_q]),
		.start     (src_base_q[act_q]),
		.inc       (ac.src_inc),
		.rld       (ac.src_rld),
		.burst_end (burst_end),
		.block_end (block_end),
		.txn_end   (txn_end),
		.nxt       (src_nxt)
	);

	fcdma_addr u_dst (
		.cur       (dst_cur_q[act_q]),
		.start     (dst_base_q[act_q]),
		.inc       (ac.dst_inc),
		.rld       (ac.dst_rld),
		.burst_end (burst_end),
		.block_end (block_end),
		.txn_end   (txn_end),
		.nxt       (dst_nxt)
	);

	// Read data captured in the setup phase
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= '0;
			if (a_is_ch) begin
				case (a_ofs)
					OFS_CTRL: prdata_q <= ctrl_q[a_ch];
					OFS_SRC:  prdata_q <= {16'h0000, src_cur_q[a_ch]};
					OFS_DST:  prdata_q <= {16'h0000, dst_cur_q[a_ch]};
					OFS_CNT:  prdata_q <= {rem_q[a_ch][AW-1:0], blk_q[a_ch]};
					default:  prdata_q <= '0;
				endcase
			end else if (paddr == OFS_GCTRL) begin
				prdata_q <= {28'h0000000, gctrl_q};
			end else if (paddr == OFS_STAT) begin
				prdata_q <= {16'h0000, busy, match_q, err_q, done_q};
			end
		end
	end

	// Global control
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gctrl_q <= '0;
		end else if (apb_wr && paddr == OFS_GCTRL) begin
			gctrl_q <= pwdata[GCW-1:0];
		end
	end

	// Channel settings and live addresses and counts
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NCH; i++) begin
				ctrl_q[i]     <= '0;
				src_base_q[i] <= '0;
				dst_base_q[i] <= '0;
				src_cur_q[i]  <= '0;
				dst_cur_q[i]  <= '0;
				blk_q[i]      <= '0;
				rem_q[i]      <= BLK_MAX;
			end
			rep_q <= '0;
		end else begin
			if (apb_wr && a_is_ch) begin
				case (a_ofs)
					OFS_CTRL: ctrl_q[a_ch] <= fcdma_ctrl_s'(pwdata & CTRL_WMASK);
					OFS_SRC: begin
						src_base_q[a_ch] <= pwdata[AW-1:0];
						src_cur_q[a_ch]  <= pwdata[AW-1:0];
					end
					OFS_DST: begin
						dst_base_q[a_ch] <= pwdata[AW-1:0];
						dst_cur_q[a_ch]  <= pwdata[AW-1:0];
					end
					OFS_CNT: begin
						blk_q[a_ch] <= pwdata[AW-1:0];
						rem_q[a_ch] <= blk_len(pwdata[AW-1:0]);
						rep_q[a_ch] <= 1'b0;
					end
					default: rep_q <= rep_q;
				endcase
			end
			if (wr_ack) begin
				src_cur_q[act_q] <= src_nxt;
				dst_cur_q[act_q] <= dst_nxt;
				rem_q[act_q]     <= rem_q[act_q] - BLK_ONE;
				if (txn_end) begin
					ctrl_q[act_q].en <= 1'b0;
					rep_q[act_q]     <= 1'b0;
					rem_q[act_q]     <= blk_len(blk_q[act_q]);
					if (ac.link) ctrl_q[nxt_ch].en <= 1'b1;
				end else if (block_end) begin
					rep_q[act_q] <= 1'b1;
					rem_q[act_q] <= blk_len(blk_q[act_q]);
				end
			end
			if (bus_err) ctrl_q[act_q].en <= 1'b0;
		end
	end

	// Pending triggers: a new trigger wins over the grant clearing it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= '0;
		end else begin
			pend_q <= (pend_q & ~pend_clr) | pend_set;
		end
	end

	// Sticky flags, write one to clear, set wins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q  <= '0;
			err_q   <= '0;
			match_q <= '0;
		end else begin
			if (apb_wr && paddr == OFS_STAT) begin
				done_q  <= done_q & ~pwdata[SF_DONE +: NCH];
				err_q   <= err_q & ~pwdata[SF_ERR +: NCH];
				match_q <= match_q & ~pwdata[SF_MATCH +: NCH];
			end
			if (txn_end) done_q[act_q] <= 1'b1;
			if (bus_err) err_q[act_q] <= 1'b1;
			if (wr_ack && match_w) match_q[act_q] <= 1'b1;
		end
	end

	// Burst engine: read a byte, write it, repeat within the burst
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= ST_IDLE;
			act_q  <= '0;
			beat_q <= 1'b0;
			data_q <= '0;
			mem_q  <= '0;
		end else begin
			case (st_q)
				ST_IDLE: if (start) begin
					act_q  <= gnt_idx;
					beat_q <= 1'b0;
					mem_q  <= '{req: 1'b1, we: 1'b0, addr: src_cur_q[gnt_idx], wdata: 8'h00};
					st_q   <= ST_RD;
				end
				ST_RD: if (bus_err) begin
					mem_q.req <= 1'b0;
					st_q      <= ST_IDLE;
				end else if (rd_ack) begin
					data_q      <= mem_rdata;
					mem_q.we    <= 1'b1;
					mem_q.addr  <= dst_cur_q[act_q];
					mem_q.wdata <= mem_rdata;
					st_q        <= ST_WR;
				end
				ST_WR: if (bus_err) begin
					mem_q.req <= 1'b0;
					st_q      <= ST_IDLE;
				end else if (burst_end) begin
					mem_q.req <= 1'b0;
					mem_q.we  <= 1'b0;
					st_q      <= ST_IDLE;
				end else if (wr_ack) begin
					beat_q <= 1'b1;
					mem_q  <= '{req: 1'b1, we: 1'b0, addr: src_nxt, wdata: 8'h00};
					st_q   <= ST_RD;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Bytes written are handed to the CRC generator
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_valid_q <= 1'b0;
			crc_data_q  <= '0;
		end else begin
			crc_valid_q <= wr_ack && ac.crc;
			if (wr_ack && ac.crc) crc_data_q <= mem_q.wdata;
		end
	end

	// Checks on the engine
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_rd_done;
		st_q == ST_RD && mem_ack && !mem_err;
	endsequence
	sequence s_wr_issue;
		st_q == ST_WR && mem_q.req && mem_q.we;
	endsequence

	AST_RD_THEN_WR: assert property (s_rd_done |=> s_wr_issue)
		else $error("write did not follow read");
	AST_REQ_HOLD: assert property (mem_q.req && !mem_ack |=>
		mem_q.req && $stable(mem_q.addr) && $stable(mem_q.we))
		else $error("request changed before ack");
	AST_BURST2: assert property (wr_ack && ac.burst2 && !beat_q && !last_byte && !match_w
		|=> st_q == ST_RD && mem_q.req && act_q == $past(act_q))
		else $error("two-byte burst was broken");
	AST_GRANT: assert property (start |=> st_q == ST_RD && act_q == $past(gnt_idx))
		else $error("grant not taken");
	AST_GNT_ELIG: assert property (gnt_vld |-> elig[gnt_idx])
		else $error("granted channel not eligible");
	AST_TXN_DONE: assert property (txn_end |=> !ctrl_q[act_q].en && done_q[act_q])
		else $error("completion not flagged");
	AST_LINK: assert property (txn_end && ac.link |=>
		ctrl_q[nxt_ch].en && pend_q[nxt_ch])
		else $error("linked channel not started");
	AST_ERR: assert property (bus_err |=> !mem_q.req && err_q[act_q] && st_q == ST_IDLE)
		else $error("bus error not handled");
	AST_CRC: assert property (wr_ack && ac.crc |=>
		crc_valid && crc_data == $past(mem_q.wdata))
		else $error("byte not fed to CRC");
	AST_REPEAT: assert property (block_end && ac.rpt && !rep_q[act_q] && !match_w |=>
		rep_q[act_q] && rem_q[act_q] == blk_len(blk_q[act_q]))
		else $error("block repeat missing");
	AST_FIXED_SRC: assert property (wr_ack && !ac.src_inc && ac.src_rld == RLD_NONE |=>
		src_cur_q[act_q] == $past(src_cur_q[act_q]))
		else $error("fixed source moved");
endmodule

// ==== fcdma_mem_model.sv ====
// Byte memory answering the mover's access requests
`timescale 1ns/100ps
module fcdma_mem_model import fcdma_pkg::*; (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  fcdma_mreq_s      mem_o,
	input  wire logic        fail,
	input  wire logic [3:0]  delay,
	output logic             mem_ack,
	output logic             mem_err,
	output logic [7:0]       mem_rdata
);
	logic [7:0] mem [0:255];
	logic [3:0] cnt;
	// Known pattern in every byte
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end
	// Answer after a programmable wait; data line toggles when not answering a read
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack   <= 1'b0;
			mem_err   <= 1'b0;
			mem_rdata <= 8'h00;
			cnt       <= 4'h0;
		end else begin
			mem_ack   <= 1'b0;
			mem_err   <= 1'b0;
			mem_rdata <= ~mem_rdata; // Stale data is never left standing
			if (mem_o.req && !mem_ack) begin
				if (cnt >= delay) begin
					cnt     <= 4'h0;
					mem_ack <= 1'b1;
					mem_err <= fail; // Fault only when the bench asks
					if (mem_o.we) begin
						mem[mem_o.addr[7:0]] <= mem_o.wdata;
					end else begin
						mem_rdata <= mem[mem_o.addr[7:0]];
					end
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
endmodule

// ==== fcdma_bench.sv ====
// Self-checking bench of the four-channel memory mover
`timescale 1ns/100ps
module fcdma_bench import fcdma_pkg::*;;
	logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, mem_ack, mem_err, crc_valid, fail = 1'b0, se;
	logic [7:0] mem_rdata, crc_data;
	logic [3:0] periph_req = 4'h0, evt_trig = 4'h0, irq_done, irq_err, delay = 4'h0;
	fcdma_mreq_s mem_o;
	fcdma_ctrl_s c;
	logic [15:0] wq [$];
	int err_total = 0, samples_checked = 0, crc_n = 0;
	fcdma_top fcdma_top_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_o(mem_o), .mem_ack(mem_ack), .mem_err(mem_err),
		.mem_rdata(mem_rdata), .periph_req(periph_req), .evt_trig(evt_trig),
		.crc_valid(crc_valid), .crc_data(crc_data), .irq_done(irq_done), .irq_err(irq_err));
	fcdma_mem_model fcdma_mem_model_i (.core_clk(core_clk), .rst_n(rst_n), .mem_o(mem_o),
		.fail(fail), .delay(delay), .mem_ack(mem_ack), .mem_err(mem_err),
		.mem_rdata(mem_rdata));
	// Clock at 250 MHz
	always #2 core_clk = ~core_clk;
	// Record write addresses and checksum feed pulses
	always @(posedge core_clk) begin
		if (mem_o.req === 1'b1 && mem_o.we === 1'b1 && mem_ack === 1'b1) wq.push_back(mem_o.addr);
		if (crc_valid === 1'b1) crc_n++;
	end
	function automatic logic [7:0] pat(input logic [7:0] a);
		return a ^ 8'h5a;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata; se = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic cfg(input int ch, input logic [15:0] s, input logic [15:0] d,
			input logic [15:0] n);
		apb(1, 8'(ch*16 + 4), {16'h0, s}); apb(1, 8'(ch*16 + 8), {16'h0, d});
		apb(1, 8'(ch*16 + 12), {16'h0, n}); apb(1, 8'(ch*16), 32'(c));
	endtask
	task automatic base_ctrl();
		c = '0; c.en = 1'b1; c.src_inc = 1'b1; c.dst_inc = 1'b1; c.ie_done = 1'b1; c.ie_err = 1'b1;
	endtask
	task automatic wait_irq(input int ch);
		for (int i = 0; i < 2000 && irq_done[ch] !== 1'b1 && irq_err[ch] !== 1'b1; i++) @(posedge core_clk);
		@(posedge core_clk);
	endtask
	task automatic wait_wr(input int n);
		for (int i = 0; i < 2000 && wq.size() < n; i++) @(posedge core_clk);
		repeat (2) @(posedge core_clk);
	endtask
	// Reset values, per-channel storage, unmapped access
	task automatic s_regs();
		apb(0, OFS_CTRL, 0); chk(rd, 32'h0);
		apb(1, 8'h14, 32'h0000_1234); apb(0, 8'h14, 0); chk(rd, 32'h0000_1234);
		apb(0, 8'h04, 0); chk(rd, 32'h0);
		apb(1, 8'h2c, 32'h0000_0005); apb(0, 8'h2c, 0); chk(rd, 32'h0005_0005);
		apb(0, 8'h50, 0); chk({rd[30:0], se}, 32'h1);
	endtask
	// Two-byte software burst, slow memory, checksum feed
	task automatic s_burst2();
		base_ctrl(); c.burst2 = 1'b1; c.crc = 1'b1; delay <= 4'h3; crc_n = 0;
		cfg(0, 16'h0010, 16'h0080, 16'h0002); apb(1, OFS_CTRL, 32'(c) | 32'h2);
		wait_irq(0); delay <= 4'h0;
		chk(irq_done[0], 1);
		chk(fcdma_mem_model_i.mem[8'h80], pat(8'h10));
		chk(fcdma_mem_model_i.mem[8'h81], pat(8'h11));
		chk(crc_n, 2);
		chk(crc_data, pat(8'h11));
		apb(1, OFS_STAT, 32'h1);
		@(posedge core_clk);
		chk(irq_done[0], 0);
	endtask
	// Repeated one-byte block from a reloaded source, peripheral trigger
	task automatic s_repeat();
		base_ctrl(); c.rpt = 1'b1; c.trig = TRG_PER; c.src_rld = RLD_BURST; wq.delete();
		cfg(1, 16'h0020, 16'h0090, 16'h0001);
		@(posedge core_clk) periph_req[1] <= 1'b1;
		@(posedge core_clk) periph_req[1] <= 1'b0;
		wait_wr(1); chk(irq_done[1], 0);
		@(posedge core_clk) periph_req[1] <= 1'b1;
		@(posedge core_clk) periph_req[1] <= 1'b0;
		wait_irq(1); chk(irq_done[1], 1);
		chk(fcdma_mem_model_i.mem[8'h91], pat(8'h20));
		apb(1, OFS_STAT, 32'h2);
	endtask
	// Failed access on an event-started channel
	task automatic s_error();
		base_ctrl(); c.trig = TRG_EVT; fail <= 1'b1;
		cfg(2, 16'h0040, 16'h00d0, 16'h0001);
		@(posedge core_clk) evt_trig[2] <= 1'b1;
		@(posedge core_clk) evt_trig[2] <= 1'b0;
		wait_irq(2); fail <= 1'b0;
		chk({irq_err[2], irq_done[2]}, 2'b10);
		apb(0, 8'h20, 0); chk(rd[0], 0);
		apb(1, OFS_STAT, 32'h44); apb(0, OFS_STAT, 0); chk(rd[7:0], 0);
	endtask
	// Completion of one channel starts the next
	task automatic s_link();
		base_ctrl(); c.trig = TRG_EVT; cfg(3, 16'h0031, 16'h00a1, 16'h0001);
		base_ctrl(); c.link = 1'b1; c.ie_done = 1'b0; cfg(2, 16'h0041, 16'h00a0, 16'h0001);
		apb(1, 8'h20, 32'(c) | 32'h2); wait_irq(3);
		chk(irq_done[3], 1);
		chk(fcdma_mem_model_i.mem[8'ha0], pat(8'h41));
		chk(fcdma_mem_model_i.mem[8'ha1], pat(8'h31));
		apb(1, OFS_STAT, 32'hf);
	endtask
	// Two simultaneous triggers served by fixed priority
	task automatic s_prio();
		base_ctrl(); c.trig = TRG_PER;
		cfg(0, 16'h0050, 16'h00b0, 16'h0001); cfg(1, 16'h0060, 16'h00c0, 16'h0001);
		wq.delete();
		@(posedge core_clk) periph_req <= 4'h3;
		@(posedge core_clk) periph_req <= 4'h0;
		wait_wr(2); chk(wq.size(), 2);
		chk(wq[0], 16'h00b0);
		chk(wq[1], 16'h00c0);
	endtask
	// Odd channel of a pair waits, then runs once unpaired, fixed source
	task automatic s_pair();
		base_ctrl(); c.src_inc = 1'b0;
		apb(1, OFS_STAT, 32'h0fff); apb(1, OFS_GCTRL, 32'h5);
		cfg(1, 16'h0078, 16'h00e8, 16'h0001); apb(1, 8'h10, 32'(c) | 32'h2);
		repeat (20) @(posedge core_clk);
		chk(irq_done[1], 0);
		chk(fcdma_mem_model_i.mem[8'he8], pat(8'he8));
		apb(1, OFS_GCTRL, 32'h1); wait_irq(1);
		chk(irq_done[1], 1);
		chk(fcdma_mem_model_i.mem[8'he8], pat(8'h78));
		apb(0, 8'h14, 0); chk(rd, 32'h0000_0078);
	endtask
	// Search ends the transaction on the matching byte
	task automatic s_search();
		base_ctrl(); c.search = 1'b1; c.pattern = pat(8'h71); c.dst_rld = RLD_TXN; wq.delete();
		cfg(0, 16'h0070, 16'h00e0, 16'h0004); apb(1, OFS_CTRL, 32'(c) | 32'h2);
		wait_wr(1); chk(irq_done[0], 0);
		apb(1, OFS_CTRL, 32'(c) | 32'h2); wait_irq(0);
		chk(fcdma_mem_model_i.mem[8'he1], pat(8'h71));
		apb(0, OFS_STAT, 0); chk({rd[8], rd[0]}, 2'b11);
		apb(0, OFS_DST, 0); chk(rd, 32'h0000_00e0);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#200000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		s_regs();
		apb(1, OFS_GCTRL, 32'h1);
		s_burst2();
		s_repeat();
		s_error();
		s_link();
		s_prio();
		s_pair();
		s_search();
		tally_and_finish();
	end
endmodule
